// *** verilog/boag_addr_gen.sv ***
// boag_addr_gen: program counter and operand address generator of the core
// assumes the decoder holds op inputs valid for one cycle per step and the
// memory returns table read data in the cycle after the address is shown
// Notes on behaviour
// - sequential fetch adds instruction length to counter
// - relative branch adds displacement to next address
// - displacement sign-extended from bit 7
// - short branch and conditionals use relative target
// - absolute call and branch load immediate
// - table call index taken from bits 1-5
// - table call reads target from 40H-7FH
// - register branch copies accumulator pair
// - direct operand uses 16-bit immediate address
// - short operand reaches FE20H to FF1FH
// - bytes 20H-FFH give upper byte FEH
// - bytes 00H-1FH set address bit 8
// - window splits into RAM and registers
`timescale 1ns/1ps
module boag_addr_gen #(
  parameter int ADDR_WIDTH = boag_pkg::ADDR_W
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // decoder request
  input wire logic op_valid_in,
  input wire boag_pkg::boag_op_type op_in,
  input wire logic [2:0] instr_len_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] signed_branch_displacement_in,
  input wire logic [15:0] absolute_address_operand_in,
  // register file
  input wire logic [15:0] accumulator_pair_in,
  // operand addressing request
  input wire logic am_valid_in,
  input wire boag_pkg::boag_am_type am_in,
  input wire logic [7:0] short_operand_in,
  // table read data from memory
  input wire logic [7:0] mem_rdata_in,
  // program counter and table fetch
  output logic [15:0] pc_out,
  output logic busy_out,
  output logic tbl_rd_out,
  output logic [15:0] tbl_addr_out,
  // operand address
  output logic [15:0] ea_out,
  output logic ea_valid_out,
  output logic ea_sel_ram_out,
  output logic ea_sel_sfr_out
);
  import boag_pkg::*;

  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [15:0] disp_ext;
  logic [15:0] tbl_entry;
  logic [IDX_W-1:0] table_index_field;
  logic [7:0] tbl_lo_r;
  logic busy_r;
  logic tbl_rd_r;
  logic [15:0] tbl_addr_r;
  logic [15:0] ea_r;
  logic ea_valid_r;
  logic sel_ram_r;
  logic sel_sfr_r;
  boag_state_type st_r;
  boag_state_type st_nxt;
  boag_short_if sif ();

  // sign fill of the displacement
  assign disp_ext = {{8{signed_branch_displacement_in[DISP_SIGN_BIT]}}, signed_branch_displacement_in};

  // index sits above bit 0 so entries fall on even addresses
  assign table_index_field = opcode_in[IDX_LSB +: IDX_W];
  assign tbl_entry = TABLE_BASE | {10'h000, table_index_field, 1'b0};

  // next counter value; carries above bit 15 are dropped by the width
  always_comb begin
    pc_nxt = pc_r;
    case (op_in)
      BOAG_OP_SEQ: pc_nxt = 16'(pc_r + {13'h0000, instr_len_in});
      // pc_r plus length is the start of the following instruction
      BOAG_OP_REL: pc_nxt = 16'(pc_r + {13'h0000, instr_len_in} + disp_ext);
      BOAG_OP_ABS: pc_nxt = absolute_address_operand_in;
      BOAG_OP_REG: pc_nxt = accumulator_pair_in;
      // hold and table calls leave the counter here; the sequencer loads it
      default: pc_nxt = pc_r;
    endcase
  end

  // table call sequencer: even strobe, odd strobe, then load; each byte lags
  // its strobe by one cycle, so the target lands two cycles after the odd strobe
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      BOAG_ST_IDLE: begin
        if (op_valid_in && op_in == BOAG_OP_TBL) begin
          st_nxt = BOAG_ST_LO;
        end
      end
      BOAG_ST_LO: st_nxt = BOAG_ST_HI;
      BOAG_ST_HI: st_nxt = BOAG_ST_LOAD;
      BOAG_ST_LOAD: st_nxt = BOAG_ST_IDLE;
      default: st_nxt = BOAG_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= BOAG_ST_IDLE;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  // table read strobe and address; requests are ignored while busy
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tbl_rd_r <= 1'b0;
      tbl_addr_r <= 16'h0000;
      busy_r <= 1'b0;
    end else if (ce_in) begin
      tbl_rd_r <= 1'b0;
      if (st_r == BOAG_ST_IDLE && op_valid_in && op_in == BOAG_OP_TBL) begin
        tbl_rd_r <= 1'b1;
        tbl_addr_r <= tbl_entry;
        busy_r <= 1'b1;
      end else if (st_r == BOAG_ST_LO) begin
        tbl_rd_r <= 1'b1;
        tbl_addr_r <= tbl_addr_r | 16'h0001;
      end else if (st_r == BOAG_ST_LOAD) begin
        busy_r <= 1'b0;
      end
    end
  end

  // low byte of the table entry stands the cycle after its strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tbl_lo_r <= 8'h00;
    end else if (ce_in && st_r == BOAG_ST_HI) begin
      tbl_lo_r <= mem_rdata_in;
    end
  end

  // program counter
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_r <= RESET_PC;
    end else if (ce_in) begin
      if (st_r == BOAG_ST_LOAD) begin
        pc_r <= {mem_rdata_in, tbl_lo_r};
      end else if (st_r == BOAG_ST_IDLE && op_valid_in && op_in != BOAG_OP_TBL) begin
        pc_r <= pc_nxt;
      end
    end
  end

  // short window mapping lives in its own decoder
  assign sif.short_byte = short_operand_in;
  boag_short_dec u_short (
    .sif(sif)
  );

  // effective operand address; word accesses assume software kept it even
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ea_r <= 16'h0000;
      ea_valid_r <= 1'b0;
      sel_ram_r <= 1'b0;
      sel_sfr_r <= 1'b0;
    end else if (ce_in) begin
      ea_valid_r <= 1'b0;
      if (am_valid_in && am_in == BOAG_AM_DIRECT) begin
        ea_r <= absolute_address_operand_in;
        ea_valid_r <= 1'b1;
        sel_ram_r <= 1'b0;
        sel_sfr_r <= 1'b0;
      end else if (am_valid_in && am_in == BOAG_AM_SHORT) begin
        ea_r <= sif.short_addr;
        ea_valid_r <= 1'b1;
        sel_ram_r <= sif.sel_ram;
        sel_sfr_r <= sif.sel_sfr;
      end
    end
  end

  assign pc_out = pc_r;
  assign busy_out = busy_r;
  assign tbl_rd_out = tbl_rd_r;
  assign tbl_addr_out = tbl_addr_r;
  assign ea_out = ea_r;
  assign ea_valid_out = ea_valid_r;
  assign ea_sel_ram_out = sel_ram_r;
  assign ea_sel_sfr_out = sel_sfr_r;

  // checks next to the logic
  a_seq_advance: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && op_valid_in && op_in == BOAG_OP_SEQ && st_r == BOAG_ST_IDLE
    |=> pc_r == 16'($past(pc_r) + {13'h0000, $past(instr_len_in)}))
    else $error("sequential advance wrong");
  a_rel_target: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && op_valid_in && op_in == BOAG_OP_REL && st_r == BOAG_ST_IDLE
    |=> pc_r == 16'($past(pc_r) + {13'h0000, $past(instr_len_in)}
        + {{8{$past(signed_branch_displacement_in[7])}}, $past(signed_branch_displacement_in)}))
    else $error("relative target wrong");
  a_sign_fill: assert property (@(posedge clk_in) disable iff (rst_in)
    disp_ext[15:8] == (signed_branch_displacement_in[7] ? 8'hFF : 8'h00))
    else $error("displacement sign fill wrong");
  a_abs_load: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && op_valid_in && op_in == BOAG_OP_ABS && st_r == BOAG_ST_IDLE
    |=> pc_r == $past(absolute_address_operand_in))
    else $error("absolute load wrong");
  a_tbl_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && op_valid_in && op_in == BOAG_OP_TBL && st_r == BOAG_ST_IDLE
    |=> tbl_rd_r && tbl_addr_r == {10'h001, $past(opcode_in[5:1]), 1'b0})
    else $error("table entry address wrong");
  a_tbl_load: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && st_r == BOAG_ST_LOAD |=> pc_r == {$past(mem_rdata_in), $past(tbl_lo_r)}
      && tbl_addr_r >= TABLE_BASE && tbl_addr_r <= TABLE_END)
    else $error("table target load wrong");
  a_reg_load: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && op_valid_in && op_in == BOAG_OP_REG && st_r == BOAG_ST_IDLE
    |=> pc_r == $past(accumulator_pair_in))
    else $error("register branch wrong");
  a_direct_ea: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && am_valid_in && am_in == BOAG_AM_DIRECT |=> ea_valid_r && ea_r == $past(absolute_address_operand_in))
    else $error("direct address wrong");
  a_short_ea: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && am_valid_in && am_in == BOAG_AM_SHORT
    |=> ea_r == {($past(short_operand_in) < 8'h20) ? 8'hFF : 8'hFE, $past(short_operand_in)}
        && ea_sel_sfr_out == ($past(short_operand_in) < 8'h20))
    else $error("short address wrong");

  // table sequencing: strobes, refusal while busy, release
  // a dropped request during a call must not disturb the counter
  a_tbl_strobe_odd: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && st_r == BOAG_ST_LO
    |=> tbl_rd_r && busy_r && tbl_addr_r == ($past(tbl_addr_r) | 16'h0001))
    else $error("table high byte strobe wrong");
  a_busy_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && (st_r == BOAG_ST_LO || st_r == BOAG_ST_HI)
    |=> pc_r == $past(pc_r) && busy_r)
    else $error("counter moved during table call");
  a_busy_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && st_r == BOAG_ST_LOAD |=> !busy_r && !tbl_rd_r && st_r == BOAG_ST_IDLE)
    else $error("table call did not release");
  a_tbl_lo_capture: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && st_r == BOAG_ST_HI |=> tbl_lo_r == $past(mem_rdata_in))
    else $error("table low byte not captured");
  a_rd_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && st_r == BOAG_ST_IDLE && !(op_valid_in && op_in == BOAG_OP_TBL) |=> !tbl_rd_r)
    else $error("table strobe without a call");

  // wrap and reach of the counter arithmetic
  a_seq_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && op_valid_in && op_in == BOAG_OP_SEQ && st_r == BOAG_ST_IDLE
      && (17'(pc_r) + 17'(instr_len_in)) > 17'h0FFFF
    |=> pc_r < $past(pc_r))
    else $error("sequential wrap wrong");
  a_rel_reach: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && op_valid_in && op_in == BOAG_OP_REL && st_r == BOAG_ST_IDLE
    |=> 16'(pc_r - $past(pc_r) - {13'h0000, $past(instr_len_in)} + 16'h0080) <= 16'h00FF)
    else $error("relative target out of reach");
  a_hold_op: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && op_valid_in && op_in == BOAG_OP_HOLD && st_r == BOAG_ST_IDLE |=> pc_r == $past(pc_r))
    else $error("hold moved the counter");

  // short window decode
  a_short_ram: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && am_valid_in && am_in == BOAG_AM_SHORT && short_operand_in >= SHORT_SFR_LIMIT
    |=> ea_r[15:8] == SHORT_HI_RAM && sel_ram_r && !sel_sfr_r)
    else $error("short RAM page wrong");
  a_short_sfr: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && am_valid_in && am_in == BOAG_AM_SHORT && short_operand_in < SHORT_SFR_LIMIT
    |=> ea_r[8] && ea_r[15:8] == SHORT_HI_SFR && sel_sfr_r && !sel_ram_r)
    else $error("short register page wrong");
  a_window_span: assert property (@(posedge clk_in) disable iff (rst_in)
    ea_valid_r && (sel_ram_r || sel_sfr_r) |-> ea_r >= 16'hFE20 && ea_r <= 16'hFF1F)
    else $error("short address outside window");
  a_window_split: assert property (@(posedge clk_in) disable iff (rst_in)
    ea_valid_r && (sel_ram_r || sel_sfr_r)
    |-> sel_ram_r == (ea_r <= 16'hFEFF) && sel_sfr_r == (ea_r >= 16'hFF00))
    else $error("short window split wrong");

  // operand strobe and direct selects
  a_ea_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !am_valid_in |=> !ea_valid_r)
    else $error("operand valid not a pulse");
  a_ea_stand: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !am_valid_in |=> ea_r == $past(ea_r) && sel_ram_r == $past(sel_ram_r))
    else $error("operand address did not stand");
  a_direct_sel: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && am_valid_in && am_in == BOAG_AM_DIRECT |=> !sel_ram_r && !sel_sfr_r)
    else $error("direct access raised a window select");
  // a low enable must leave the counter, state, busy, operand address and valid where they were, mid call too
  a_ce_freeze: assert property (@(posedge clk_in) disable iff (rst_in)
    !ce_in |=> pc_r == $past(pc_r) && st_r == $past(st_r) && busy_r == $past(busy_r)
      && ea_r == $past(ea_r) && ea_valid_r == $past(ea_valid_r))
    else $error("state moved with enable low");
endmodule // boag_addr_gen

// *** verilog/boag_pkg.sv ***
// boag_pkg: constants shared by the branch and operand address generator
// assumes a 16-bit address space and an 8-bit core
package boag_pkg;
  localparam int ADDR_W = 16;
  localparam int DISP_W = 8;
  localparam int IDX_W = 5;
  // sign bit of the displacement and index field position in the opcode
  localparam int DISP_SIGN_BIT = 7;
  localparam int IDX_LSB = 1;
  // table base for the table call, entries are two bytes
  localparam logic [15:0] TABLE_BASE = 16'h0040;
  localparam logic [15:0] TABLE_END = 16'h007F;
  // short window
  localparam logic [7:0] SHORT_HI_RAM = 8'hFE;
  localparam logic [7:0] SHORT_HI_SFR = 8'hFF;
  localparam logic [7:0] SHORT_SFR_LIMIT = 8'h20;
  localparam logic [15:0] RESET_PC = 16'h0000;
  // branch / fetch operation codes
  typedef enum logic [2:0] {
    BOAG_OP_SEQ = 3'b000,
    BOAG_OP_REL = 3'b001,
    BOAG_OP_ABS = 3'b010,
    BOAG_OP_TBL = 3'b011,
    BOAG_OP_REG = 3'b100,
    BOAG_OP_HOLD = 3'b101
  } boag_op_type;
  // operand addressing modes
  typedef enum logic [1:0] {
    BOAG_AM_NONE = 2'b00,
    BOAG_AM_DIRECT = 2'b01,
    BOAG_AM_SHORT = 2'b10
  } boag_am_type;
  // table call sequencer states
  typedef enum logic [1:0] {
    BOAG_ST_IDLE = 2'b00,
    BOAG_ST_LO = 2'b01,
    BOAG_ST_HI = 2'b10,
    BOAG_ST_LOAD = 2'b11
  } boag_state_type;
endpackage

// *** verilog/boag_short_if.sv ***
// boag_short_if: carries a short operand byte to the short-window decoder
// assumes both ends share clk_in; purely combinational signals
`timescale 1ns/1ps
interface boag_short_if;
  logic [7:0] short_byte;
  logic [15:0] short_addr;
  logic sel_ram;
  logic sel_sfr;
  modport ctrl (output short_byte, input short_addr, sel_ram, sel_sfr);
  modport dec (input short_byte, output short_addr, sel_ram, sel_sfr);
endinterface

// *** verilog/boag_short_dec.sv ***
// boag_short_dec: maps an 8-bit short operand into the FE20H..FF1FH window
// assumes the caller registers the results
`timescale 1ns/1ps
module boag_short_dec (
  // decoder side of the short operand carrier
  boag_short_if.dec sif
);
  import boag_pkg::*;
  logic low_byte;

  // bytes below 20H wrap up into the register page
  assign low_byte = (sif.short_byte < SHORT_SFR_LIMIT);
  assign sif.short_addr = {(low_byte ? SHORT_HI_SFR : SHORT_HI_RAM), sif.short_byte};
  // the window has no gap, so one compare picks RAM or registers
  assign sif.sel_ram = ~low_byte;
  assign sif.sel_sfr = low_byte;
endmodule // boag_short_dec

// *** tb/boag_mem_model.sv ***
// boag_mem_model: table memory seen by the address generator
// assumes one-cycle read latency, a byte pattern derived from the address
`timescale 1ns/1ps
module boag_mem_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // read strobe and address from the generator
  input wire logic tbl_rd_in,
  input wire logic [15:0] tbl_addr_in,
  // returned byte
  output logic [7:0] mem_rdata_out
);
  // byte one cycle after the strobe; otherwise invert so stale data never looks valid
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_rdata_out <= 8'h00;
    end else if (tbl_rd_in) begin
      mem_rdata_out <= tbl_addr_in[7:0] ^ 8'hA5;
    end else begin
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule // boag_mem_model

// *** tb/branch_operand_address_gen_tb_top.sv ***
// branch_operand_address_gen_tb_top: self-checking bench of the address generator
// assumes the memory model answers table reads; the bench plays decoder and registers
`timescale 1ns/1ps
module branch_operand_address_gen_tb_top;
  import boag_pkg::*;
  logic clk_in = 0, rst_in = 1, ce_in = 1, op_valid_in = 0, am_valid_in = 0;
  boag_op_type op_in = BOAG_OP_SEQ;
  boag_am_type am_in = BOAG_AM_NONE;
  logic [2:0] instr_len_in = 3'h0;
  logic [7:0] opcode_in = 8'h00, signed_branch_displacement_in = 8'h00, short_operand_in = 8'h00, mem_rdata_in;
  logic [15:0] absolute_address_operand_in = 16'h0000, accumulator_pair_in = 16'h0000;
  logic [15:0] pc_out, tbl_addr_out, ea_out;
  logic busy_out, tbl_rd_out, ea_valid_out, ea_sel_ram_out, ea_sel_sfr_out;
  int errors = 0, checks = 0, cyc = 0;

  boag_addr_gen dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .op_valid_in(op_valid_in), .op_in(op_in),
    .instr_len_in(instr_len_in), .opcode_in(opcode_in), .signed_branch_displacement_in(signed_branch_displacement_in),
    .absolute_address_operand_in(absolute_address_operand_in), .accumulator_pair_in(accumulator_pair_in),
    .am_valid_in(am_valid_in), .am_in(am_in), .short_operand_in(short_operand_in), .mem_rdata_in(mem_rdata_in),
    .pc_out(pc_out), .busy_out(busy_out), .tbl_rd_out(tbl_rd_out), .tbl_addr_out(tbl_addr_out), .ea_out(ea_out),
    .ea_valid_out(ea_valid_out), .ea_sel_ram_out(ea_sel_ram_out), .ea_sel_sfr_out(ea_sel_sfr_out));
  boag_mem_model mem (.clk_in(clk_in), .rst_in(rst_in), .tbl_rd_in(tbl_rd_out), .tbl_addr_in(tbl_addr_out),
    .mem_rdata_out(mem_rdata_in));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  // a hang stops here rather than running forever
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // one op pulse; the leading edge keeps valid low across an edge between calls
  task automatic issue(input boag_op_type o);
    @(posedge clk_in);
    #1;
    op_in = o;
    op_valid_in = 1;
    @(posedge clk_in);
    #1;
    op_valid_in = 0;
  endtask
  // every counter op but the table call, wrap past FFFFH, hold, and a request under a low enable
  task automatic branches();
    issue(BOAG_OP_SEQ);
    chk(pc_out, RESET_PC);
    instr_len_in = 3'h3;
    issue(BOAG_OP_SEQ);
    chk(pc_out, 16'h0003);
    absolute_address_operand_in = 16'hFFFF;
    issue(BOAG_OP_ABS);
    chk(pc_out, 16'hFFFF);
    instr_len_in = 3'h2;
    issue(BOAG_OP_SEQ);
    chk(pc_out, 16'h0001);
    absolute_address_operand_in = 16'h1000;
    issue(BOAG_OP_HOLD);
    chk(pc_out, 16'h0001);
    issue(BOAG_OP_ABS);
    signed_branch_displacement_in = 8'h80;
    issue(BOAG_OP_REL);
    chk(pc_out, 16'h0F82);
    signed_branch_displacement_in = 8'h7F;
    issue(BOAG_OP_REL);
    chk(pc_out, 16'h1003);
    absolute_address_operand_in = 16'hFFF0;
    issue(BOAG_OP_ABS);
    issue(BOAG_OP_REL);
    chk(pc_out, 16'h0071);
    accumulator_pair_in = 16'hBEEF;
    ce_in = 0;
    issue(BOAG_OP_REG);
    chk(pc_out, 16'h0071);
    ce_in = 1;
    issue(BOAG_OP_REG);
    chk(pc_out, 16'hBEEF);
  endtask
  // table call at both ends of the index range; an op during the call is refused
  task automatic table_calls();
    logic [7:0] opc [2] = '{8'hFF, 8'hC0};
    logic [15:0] a;
    logic [15:0] prev;
    int n;
    prev = 16'hBEEF;
    foreach (opc[i]) begin
      opcode_in = opc[i];
      a = TABLE_BASE | {10'h000, opc[i][5:1], 1'b0};
      issue(BOAG_OP_TBL);
      chk({14'h0, tbl_rd_out, busy_out}, 16'h0003);
      chk(tbl_addr_out, a);
      absolute_address_operand_in = 16'h5555;
      issue(BOAG_OP_ABS);
      chk(pc_out, prev);
      n = 0;
      while (busy_out !== 1'b0 && n < 10) begin
        @(posedge clk_in);
        #1;
        n++;
      end
      chk(16'(n), 16'h0001);
      prev = {a[7:0] ^ 8'hA4, a[7:0] ^ 8'hA5};
      chk(pc_out, prev);
    end
  endtask
  // back-to-back operand requests over both window halves and the boundaries
  task automatic operands();
    // byte accesses only; a word access would have to start on an even byte
    logic [7:0] b [4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};
    am_valid_in = 1;
    am_in = BOAG_AM_DIRECT;
    absolute_address_operand_in = 16'h1234;
    @(posedge clk_in);
    #1;
    chk(ea_out, 16'h1234);
    chk({13'h0, ea_valid_out, ea_sel_ram_out, ea_sel_sfr_out}, 16'h0004);
    am_in = BOAG_AM_SHORT;
    foreach (b[i]) begin
      short_operand_in = b[i];
      @(posedge clk_in);
      #1;
      chk(ea_out, {(b[i] < 8'h20) ? 8'hFF : 8'hFE, b[i]});
      chk({13'h0, ea_valid_out, ea_sel_ram_out, ea_sel_sfr_out},
        {13'h0, 1'b1, b[i] >= 8'h20, b[i] < 8'h20});
    end
    am_valid_in = 0;
    @(posedge clk_in);
    #1;
    chk({15'h0, ea_valid_out}, 16'h0000);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    #1 rst_in = 0;
    chk(pc_out, 16'h0000);
    @(posedge clk_in);
    #1;
    branches();
    table_calls();
    operands();
    wrap_up();
  end
endmodule // branch_operand_address_gen_tb_top
